// File: src/ppc_pkg.sv
package ppc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHROMA = 8'h04;
  localparam logic [7:0] OFS_KEY = 8'h08;
  localparam logic [7:0] OFS_MASK_Y = 8'h0C;
  localparam logic [7:0] OFS_MASK_U = 8'h10;
  localparam logic [7:0] OFS_MASK_V = 8'h14;
  localparam logic [7:0] OFS_TABLE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // Field layout of control, key, mask and table words
  localparam int CTRL_W = 13;
  localparam int CNT_W = 3;
  localparam int KEY_LSB = 0;
  localparam int AMATCH_LSB = 8;
  localparam int AMISS_LSB = 16;
  localparam int MSET_LSB = 0;
  localparam int MDATA_LSB = 8;
  localparam int TADDR_LSB = 24;
  localparam int TY_LSB = 0;
  localparam int TU_LSB = 8;
  localparam int TV_LSB = 16;
  // 6-5-5 pixel fields
  localparam int F16_YW = 6;
  localparam int F16_CW = 5;
  // Chroma sample count coding
  localparam logic [2:0] CNT_OFF = 3'h0;
  localparam logic [2:0] CNT_FULL = 3'h7;
  localparam logic [8:0] SAMP_STEP = 9'h020;
  localparam logic [8:0] SAMP_FULL_M1 = 9'h0FF;
  // Chroma line store layout
  localparam logic [8:0] U_BASE = 9'h100;
  localparam logic [1:0] LAST_BANK = 2'h2;
  localparam int STORE_DEPTH = 1536;
  // Interpolation grid
  localparam logic [2:0] GRID_2 = 3'h2;
  localparam logic [2:0] GRID_4 = 3'h4;
  localparam int SH_2 = 2;
  localparam int SH_4 = 4;
  // Reset values
  localparam logic [31:0] KEY_RST = 32'h0000_0000;
  localparam logic [15:0] MASK_RST = 16'h0000;

  typedef enum logic [1:0] {
    FMT_8 = 2'b00, FMT_P16 = 2'b01, FMT_16 = 2'b10, FMT_32 = 2'b11
  } ppc_fmt_t;
  typedef enum logic [1:0] {
    PT_GFX = 2'b00, PT_VID = 2'b01, PT_MIX = 2'b10, PT_RSV = 2'b11
  } ppc_ptype_t;
  typedef struct packed {
    logic exp4;
    logic dbl;
    logic rnd;
    logic gate;
    logic vbyp;
    logic gbyp;
    logic split;
    logic cond;
    logic sw_u;
    ppc_ptype_t ptype;
    ppc_fmt_t fmt;
  } ppc_ctrl_t;
  localparam ppc_ctrl_t CTRL_RST = 13'h0000;
  typedef struct packed {
    logic [7:0] alpha;
    logic [7:0] v;
    logic [7:0] u;
    logic [7:0] y;
  } ppc_pix_t;
endpackage

// File: src/ppc_pixel_path.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Split words into 8/16/32-bit or pseudo pixels
// - Mixed mode: flag LSB picks explicit or chroma
// - Y flag leaves seven luminance bits
// - 32-bit and pseudo 16 carry alpha
// - Alpha key: Y match picks alpha value
// - Chroma line: N V bytes, N U bytes
// - N is 256 or 32..192 by 32
// - First samples anchor grid of 2 or 4
// - Between known pixels use weighted average
// - Truncate or round to nearest odd
// - Repeat last sample past loaded width
// - Doubling uses each chroma twice horizontally
// - Interpolate only with nonzero count, active fetch
// - U flag zero disables whole block
// - Y flag zero disables single pixel
// - Gate off loads but hides chroma
// - Three 256x8 tables, separate or joint
// - Mask set bits take mask data
// - Split mode forces all address LSBs
// - Otherwise flag picks half of carrier
// - Graphics and video bypass skip tables
// - Split: video odd, graphics even entries
// - Flag zero graphics: 8-bit and pseudo 16 Y addresses all tables
module ppc_pixel_path (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Display timing
  input wire logic line_start,
  input wire logic frame_start,
  input wire logic disp_active,
  // Pixel words from memory
  input wire logic [31:0] word_data,
  input wire logic word_valid,
  output logic word_ready,
  // Chroma line words
  input wire logic [31:0] chroma_data,
  input wire logic chroma_valid,
  input wire logic chroma_line_done,
  // Pixel output
  output ppc_pkg::ppc_pix_t pix_out,
  output logic pix_valid
);
  import ppc_pkg::*;

  function automatic logic [2:0] ppw(input ppc_fmt_t f);
    case (f)
      FMT_8: ppw = 3'h4;
      FMT_32: ppw = 3'h1;
      default: ppw = 3'h2;
    endcase
  endfunction

  function automatic logic [8:0] nsamp_m1(input logic [2:0] c);
    if (c == CNT_FULL)
      nsamp_m1 = SAMP_FULL_M1;
    else
      nsamp_m1 = 9'(SAMP_STEP * 9'(c)) - 9'h001;
  endfunction

  function automatic logic [1:0] bnext(input logic [1:0] b);
    bnext = (b == LAST_BANK) ? 2'h0 : b + 2'h1;
  endfunction

  function automatic logic [7:0] mask(input logic [7:0] d, s, m);
    mask = (s & m) | (~s & d);
  endfunction

  function automatic logic [7:0] interp4(input logic [7:0] a, b, c, d,
    input logic [1:0] fx, fy, input logic e4, rnd);
    logic [2:0] e;
    logic [15:0] wx0;
    logic [15:0] wy0;
    logic [15:0] s;
    logic [15:0] q;
    logic [3:0] frac;
    e = e4 ? GRID_4 : GRID_2;
    wx0 = 16'(e - {1'b0, fx});
    wy0 = 16'(e - {1'b0, fy});
    s = 16'(a) * wx0 * wy0 + 16'(b) * 16'(fx) * wy0
      + 16'(c) * wx0 * 16'(fy) + 16'(d) * 16'(fx) * 16'(fy);
    q = e4 ? (s >> SH_4) : (s >> SH_2);
    frac = e4 ? s[3:0] : {2'b00, s[1:0]};
    if (rnd && frac != 4'h0)
      q[0] = 1'b1;
    return q[7:0];
  endfunction

  ppc_ctrl_t ctrl;
  logic [2:0] cnt_code;
  logic [31:0] keyreg;
  logic [15:0] mask_y;
  logic [15:0] mask_u;
  logic [15:0] mask_v;
  logic [7:0] tab_y [0:255];
  logic [7:0] tab_u [0:255];
  logic [7:0] tab_v [0:255];
  logic [7:0] cmem [0:STORE_DEPTH-1];
  logic [31:0] wbuf;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [9:0] xpos;
  logic [1:0] fy;
  logic [1:0] ld_bank;
  logic [8:0] lcnt;
  logic lfull;
  logic ld_en;
  ppc_pix_t s1_pix;
  logic s1_vid;
  logic s1_flag;
  logic s1_valid;
  logic s1_swy;
  logic apb_acc;
  logic apb_hit;
  logic acc;
  logic emit;
  logic interp_on;
  logic [8:0] nm1;

  assign apb_acc = psel && penable && pready;
  assign acc = word_valid && word_ready;
  assign emit = cnt != 3'h0;
  assign interp_on = cnt_code != CNT_OFF;
  assign nm1 = nsamp_m1(cnt_code);
  assign ld_en = chroma_valid && disp_active && interp_on && !lfull;

  // APB handshake: one wait state, errors on unmapped
  always_comb
  begin
    case (paddr)
      OFS_CTRL, OFS_CHROMA, OFS_KEY, OFS_MASK_Y, OFS_MASK_U, OFS_MASK_V,
      OFS_TABLE, OFS_STATUS: apb_hit = 1'b1;
      default: apb_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !apb_hit;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite)
        case (paddr)
          OFS_CTRL: prdata <= 32'(ctrl);
          OFS_CHROMA: prdata <= 32'(cnt_code);
          OFS_KEY: prdata <= keyreg;
          OFS_MASK_Y: prdata <= 32'(mask_y);
          OFS_MASK_U: prdata <= 32'(mask_u);
          OFS_MASK_V: prdata <= 32'(mask_v);
          OFS_STATUS: prdata <= {9'h000, lcnt, ld_bank, fy, xpos};
          default: prdata <= 32'h0000_0000;
        endcase
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CTRL_RST;
      cnt_code <= CNT_OFF;
      keyreg <= KEY_RST;
      mask_y <= MASK_RST;
      mask_u <= MASK_RST;
      mask_v <= MASK_RST;
    end
    else if (ce && apb_acc && pwrite)
      case (paddr)
        OFS_CTRL: ctrl <= ppc_ctrl_t'(pwdata[CTRL_W-1:0]);
        OFS_CHROMA: cnt_code <= pwdata[CNT_W-1:0];
        OFS_KEY: keyreg <= pwdata;
        OFS_MASK_Y: mask_y <= pwdata[15:0];
        OFS_MASK_U: mask_u <= pwdata[15:0];
        OFS_MASK_V: mask_v <= pwdata[15:0];
        default: ;
      endcase
  end

  // three tables, written as one 24-bit entry
  always_ff @(posedge pclk)
  begin
    if (ce && apb_acc && pwrite && paddr == OFS_TABLE)
    begin
      tab_y[pwdata[TADDR_LSB+:8]] <= pwdata[TY_LSB+:8];
      tab_u[pwdata[TADDR_LSB+:8]] <= pwdata[TU_LSB+:8];
      tab_v[pwdata[TADDR_LSB+:8]] <= pwdata[TV_LSB+:8];
    end
  end

  always_comb
  begin
    next_cnt = cnt;
    if (acc)
      next_cnt = ppw(ctrl.fmt);
    else if (emit)
      next_cnt = cnt - 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wbuf <= 32'h0000_0000;
      cnt <= 3'h0;
      word_ready <= 1'b0;
    end
    else if (ce)
    begin
      cnt <= next_cnt;
      word_ready <= next_cnt <= 3'h1;
      if (acc)
        wbuf <= word_data;
      else if (emit)
        case (ctrl.fmt)
          FMT_8: wbuf <= wbuf >> 8;
          FMT_32: wbuf <= 32'h0000_0000;
          default: wbuf <= wbuf >> 16;
        endcase
    end
  end

  // Pixel and row position
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xpos <= 10'h000;
      fy <= 2'h0;
    end
    else if (ce)
    begin
      if (line_start)
        xpos <= 10'h000;
      else if (emit)
        xpos <= xpos + 10'h001;
      if (frame_start)
        fy <= 2'h0;
      else if (line_start)
        fy <= (fy == (ctrl.exp4 ? 2'h3 : 2'h1)) ? 2'h0 : fy + 2'h1;
    end
  end

  // chroma loading only while active and enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ld_bank <= 2'h0;
      lcnt <= 9'h000;
      lfull <= 1'b0;
    end
    else if (ce)
    begin
      if (chroma_line_done)
      begin
        ld_bank <= bnext(ld_bank);
        lcnt <= 9'h000;
        lfull <= 1'b0;
      end
      else if (ld_en)
      begin
        lcnt <= lcnt + 9'h004;
        // Full flag stops a wrapped count reloading the line
        lfull <= lcnt == {nm1[7:0], 1'b1} - 9'h003;
      end
    end
  end

  // V bytes then U bytes, earliest byte lowest
  always_ff @(posedge pclk)
  begin
    if (ce && !chroma_line_done && ld_en)
      for (int i = 0; i < 4; i++)
        cmem[{ld_bank, (lcnt <= nm1) ? lcnt + 9'(i)
          : U_BASE + lcnt - nm1 - 9'h001 + 9'(i)}] <= chroma_data[8*i+:8];
  end

  // Chroma sampling position
  logic [9:0] cx;
  logic [8:0] k;
  logic [8:0] kn;
  logic [1:0] fx;
  logic [1:0] btop;
  logic [1:0] bbot;
  logic [7:0] iv;
  logic [7:0] iu;
  logic [7:0] ul_u;
  always_comb
  begin
    // each chroma value held two pixel times
    cx = ctrl.dbl ? (xpos >> 1) : xpos;
    // grid every second or fourth pixel
    k = ctrl.exp4 ? 9'(cx >> 2) : 9'(cx >> 1);
    fx = ctrl.exp4 ? cx[1:0] : {1'b0, cx[0]};
    kn = k + 9'h001;
    // hold last sample across the rest
    if (k >= nm1)
    begin
      k = nm1;
      kn = nm1;
      fx = 2'h0;
    end
    btop = bnext(ld_bank);
    bbot = bnext(btop);
    ul_u = cmem[{btop, U_BASE + k}];
    iv = interp4(cmem[{btop, k}], cmem[{btop, kn}], cmem[{bbot, k}],
      cmem[{bbot, kn}], fx, fy, ctrl.exp4, ctrl.rnd);
    iu = interp4(ul_u, cmem[{btop, U_BASE + kn}], cmem[{bbot, U_BASE + k}],
      cmem[{bbot, U_BASE + kn}], fx, fy, ctrl.exp4, ctrl.rnd);
  end

  // Pixel decode
  ppc_pix_t d_pix;
  logic d_vid;
  logic d_flag;
  logic d_swy;
  logic [7:0] ay;
  logic [7:0] gy;
  logic [7:0] gu;
  logic [7:0] gv;
  logic switching;
  always_comb
  begin
    ay = wbuf[7:0];
    gy = wbuf[7:0];
    gu = wbuf[7:0];
    gv = wbuf[7:0];
    d_pix.alpha = (ay == keyreg[KEY_LSB+:8]) ? keyreg[AMATCH_LSB+:8]
      : keyreg[AMISS_LSB+:8];
    case (ctrl.fmt)
      FMT_P16: d_pix.alpha = wbuf[15:8];
      FMT_16:
      begin
        gy = {wbuf[F16_YW-1:0], 2'b00};
        gv = {wbuf[F16_YW+F16_CW-1:F16_YW], 3'b000};
        gu = {wbuf[F16_YW+2*F16_CW-1:F16_YW+F16_CW], 3'b000};
      end
      FMT_32:
      begin
        gu = wbuf[15:8];
        gv = wbuf[23:16];
        d_pix.alpha = wbuf[31:24];
      end
      default: ;
    endcase
    switching = ctrl.ptype == PT_MIX || ctrl.cond;
    // U flag from block upper-left sample
    // Y flag from the pixel itself
    d_flag = ctrl.sw_u ? ul_u[0] : ay[0];
    d_swy = switching && !ctrl.sw_u;
    // flag one selects luminance plus chroma
    d_vid = interp_on && ctrl.gate && ctrl.ptype != PT_GFX
      && !(switching && !d_flag);
    if (d_vid)
    begin
      // seven luminance bits under Y flag
      d_pix.y = d_swy ? {ay[7:1], 1'b0} : ay;
      d_pix.u = (switching && ctrl.sw_u) ? {iu[7:1], 1'b0} : iu;
      d_pix.v = iv;
    end
    else if (ctrl.fmt == FMT_8 || ctrl.fmt == FMT_P16)
    begin
      d_pix.y = gy;
      d_pix.u = gy;
      d_pix.v = gy;
    end
    else
    begin
      d_pix.y = gy;
      d_pix.u = gu;
      d_pix.v = gv;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_pix <= '0;
      s1_vid <= 1'b0;
      s1_flag <= 1'b0;
      s1_swy <= 1'b0;
      s1_valid <= 1'b0;
    end
    else if (ce)
    begin
      s1_pix <= d_pix;
      s1_vid <= d_vid;
      s1_flag <= d_flag;
      s1_swy <= d_swy;
      s1_valid <= emit;
    end
  end

  // Table addressing
  logic [7:0] addr_y;
  logic [7:0] addr_u;
  logic [7:0] addr_v;
  logic bypass;
  always_comb
  begin
    addr_y = mask(s1_pix.y, mask_y[MSET_LSB+:8], mask_y[MDATA_LSB+:8]);
    addr_u = mask(s1_pix.u, mask_u[MSET_LSB+:8], mask_u[MDATA_LSB+:8]);
    addr_v = mask(s1_pix.v, mask_v[MSET_LSB+:8], mask_v[MDATA_LSB+:8]);
    if (ctrl.split)
    begin
      addr_y[0] = s1_vid;
      addr_u[0] = s1_vid;
      addr_v[0] = s1_vid;
    end
    else if (ctrl.ptype == PT_MIX || ctrl.cond)
    begin
      // flag keeps its own channel half
      if (s1_swy)
        addr_y[0] = s1_flag;
      else
        addr_u[0] = s1_flag;
    end
    bypass = s1_vid ? ctrl.vbyp : ctrl.gbyp;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pix_out <= '0;
      pix_valid <= 1'b0;
    end
    else if (ce)
    begin
      pix_valid <= s1_valid;
      pix_out.alpha <= s1_pix.alpha;
      pix_out.y <= bypass ? s1_pix.y : tab_y[addr_y];
      pix_out.u <= bypass ? s1_pix.u : tab_u[addr_u];
      pix_out.v <= bypass ? s1_pix.v : tab_v[addr_v];
    end
  end

  a_word_split: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && acc |=> cnt == ppw($past(ctrl.fmt)))
    else $error("word split count wrong");

  a_alpha_direct: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && emit && ctrl.fmt == FMT_32 |=> s1_pix.alpha == $past(wbuf[31:24]))
    else $error("explicit alpha not taken");

  a_alpha_key: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && emit && ctrl.fmt == FMT_8 && wbuf[7:0] == keyreg[7:0]
    |=> s1_pix.alpha == $past(keyreg[15:8]))
    else $error("key match alpha wrong");

  a_chroma_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && cnt_code == CNT_OFF |=> !s1_vid)
    else $error("interpolation with zero count");

  a_gfx_y_all: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && emit && ctrl.fmt == FMT_8 && ctrl.ptype == PT_GFX
    |=> s1_pix.u == s1_pix.y && s1_pix.v == s1_pix.y)
    else $error("graphics Y not on all tables");

  a_split_lsb: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl.split |-> addr_y[0] == s1_vid && addr_u[0] == s1_vid
      && addr_v[0] == s1_vid)
    else $error("split table LSB not forced");

  a_bypass_gfx: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && ctrl.gbyp && !s1_vid |=> pix_out.y == $past(s1_pix.y))
    else $error("graphics bypass not taken");

  a_latency: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && emit ##1 ce |=> pix_valid)
    else $error("pixel latency wrong");

  a_last_repeat: assert property (
    @(posedge pclk) disable iff (!presetn)
    interp_on |-> k <= nm1 && kn <= nm1)
    else $error("sample index beyond loaded line");
endmodule

// File: verif/ppc_mem_model.sv
`timescale 1ns/1ps
module ppc_mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pacing and display window
  input wire logic slow,
  input wire logic disp_active,
  // Pixel words
  output logic [31:0] word_data,
  output logic word_valid,
  input wire logic word_ready,
  // Chroma words
  output logic [31:0] chroma_data,
  output logic chroma_valid
);
  logic [31:0] wq[$];
  logic [31:0] cq[$];
  logic tw, tc;
  function automatic void put_word(input logic [31:0] w);
    wq.push_back(w);
  endfunction
  function automatic void put_chroma(input logic [31:0] w);
    cq.push_back(w);
  endfunction
  // Words held until taken, idle data keeps changing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_valid <= 1'h0;
      word_data <= 32'h0;
      chroma_valid <= 1'h0;
      chroma_data <= 32'h0;
    end
    else
    begin
      tw = word_valid && word_ready;
      if (tw)
        void'(wq.pop_front());
      if ((tw || !word_valid) && wq.size() > 0 &&
          (!slow || $urandom_range(1) == 1))
      begin
        word_valid <= 1'h1;
        word_data <= wq[0];
      end
      else if (tw || !word_valid)
      begin
        word_valid <= 1'h0;
        word_data <= ~word_data;
      end
      // chroma taken only in active region
      tc = chroma_valid && disp_active;
      if (tc)
        void'(cq.pop_front());
      if ((tc || !chroma_valid) && cq.size() > 0)
      begin
        chroma_valid <= 1'h1;
        chroma_data <= cq[0];
      end
      else if (tc || !chroma_valid)
      begin
        chroma_valid <= 1'h0;
        chroma_data <= ~chroma_data;
      end
    end
  end
endmodule

// File: verif/pixel_path_chroma_interp_lut_tb_top.sv
`timescale 1ns/1ps
module pixel_path_chroma_interp_lut_tb_top;
  import ppc_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, key, amatch, amiss, cu, cv;
  logic [31:0] pwdata, prdata, rd, word_data, chroma_data;
  logic line_start, frame_start, disp_active, slow, chroma_line_done;
  logic word_valid, word_ready, chroma_valid, pix_valid;
  ppc_pix_t pix_out;
  ppc_pix_t expq[$];
  ppc_ctrl_t cfg;
  logic [15:0] msk [3];
  int n_fail, comparisons;
  int cyc = 0;

  ppc_pixel_path u_ppc_pixel_path (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_start(line_start),
    .frame_start(frame_start), .disp_active(disp_active),
    .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready), .chroma_data(chroma_data),
    .chroma_valid(chroma_valid), .chroma_line_done(chroma_line_done),
    .pix_out(pix_out), .pix_valid(pix_valid));

  ppc_mem_model u_ppc_mem_model (
    .pclk(pclk), .presetn(presetn), .slow(slow),
    .disp_active(disp_active), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready),
    .chroma_data(chroma_data), .chroma_valid(chroma_valid));

  initial pclk = 1'h0;
  always #20 pclk = ~pclk;

  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] tval(input int c, input logic [7:0] i);
    if (c == 0)
      return i ^ 8'h5A;
    if (c == 1)
      return i + 8'h11;
    return ~i;
  endfunction

  function automatic ppc_pix_t expect_pix(input logic [31:0] p);
    logic vid;
    logic [7:0] a [3];
    logic [7:0] s, dt, al;
    a = '{p[7:0], p[7:0], p[7:0]};
    if (cfg.fmt == FMT_16)
      a = '{{p[5:0], 2'h0}, {p[15:11], 3'h0}, {p[10:6], 3'h0}};
    if (cfg.fmt == FMT_32)
      a = '{p[7:0], p[15:8], p[23:16]};
    al = (p[7:0] == key) ? amatch : amiss;
    if (cfg.fmt == FMT_P16)
      al = p[15:8];
    if (cfg.fmt == FMT_32)
      al = p[31:24];
    vid = cfg.gate && (cfg.ptype == PT_VID ||
          (cfg.ptype == PT_MIX && p[0]));
    if (vid)
      a = '{p[7:0], cu, cv};
    // Y flag leaves seven luminance bits
    if (vid && cfg.cond && !cfg.sw_u)
      a[0][0] = 1'b0;
    if (!(vid ? cfg.vbyp : cfg.gbyp))
      for (int c = 0; c < 3; c++)
      begin
        s = msk[c][7:0];
        dt = msk[c][15:8];
        a[c] = (s & dt) | (~s & a[c]);
        if (cfg.split)
          a[c][0] = vid;
        a[c] = tval(c, a[c]);
      end
    return {al, a[2], a[1], a[0]};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    chk("wr_err", {31'h0, er}, 32'h0);
  endtask

  task automatic pulse_line;
    @(posedge pclk);
    line_start <= 1'h1;
    @(posedge pclk);
    line_start <= 1'h0;
  endtask

  task automatic run(input ppc_fmt_t f, input ppc_ptype_t t,
                     input logic [2:0] bs, input logic g, input int nw);
    logic [31:0] w;
    int np;
    cfg = CTRL_RST;
    cfg.fmt = f;
    cfg.ptype = t;
    cfg.gbyp = bs[0];
    cfg.vbyp = bs[1];
    cfg.split = bs[2];
    cfg.gate = g;
    cfg.cond = (t == PT_MIX);
    wr(OFS_CTRL, {19'h0, cfg});
    pulse_line();
    np = (f == FMT_8) ? 4 : (f == FMT_32) ? 1 : 2;
    for (int i = 0; i < nw; i++)
    begin
      w = $urandom;
      if (i == 0)
        w[7:0] = key;
      u_ppc_mem_model.put_word(w);
      for (int k = 0; k < np; k++)
        expq.push_back(expect_pix(w >> (k * 32 / np)));
    end
    for (int n = 0; n < 3000 && expq.size() != 0; n++)
      @(posedge pclk);
    chk("drain", expq.size(), 32'h0);
    if (expq.size() != 0)
      tally_and_finish();
  endtask

  task automatic load_chroma;
    wr(OFS_CHROMA, 32'h1);
    @(posedge pclk);
    frame_start <= 1'h1;
    @(posedge pclk);
    frame_start <= 1'h0;
    repeat (3)
    begin
      disp_active <= 1'h1;
      // V bytes then U bytes, N of each
      for (int i = 0; i < 16; i++)
        u_ppc_mem_model.put_chroma(i < 8 ? {4{cv}} : {4{cu}});
      for (int n = 0; n < 200 && u_ppc_mem_model.cq.size() != 0; n++)
        @(posedge pclk);
      chk("chroma_load", u_ppc_mem_model.cq.size(), 32'h0);
      if (u_ppc_mem_model.cq.size() != 0)
        tally_and_finish();
      @(posedge pclk);
      disp_active <= 1'h0;
      chroma_line_done <= 1'h1;
      @(posedge pclk);
      chroma_line_done <= 1'h0;
    end
  endtask

  // Scoreboard on emitted pixels
  always @(posedge pclk)
  begin
    if (presetn && pix_valid === 1'h1)
    begin
      if (expq.size() == 0)
        chk("pix_extra", 32'h1, 32'h0);
      else
        chk("pix_out", pix_out, expq.pop_front());
    end
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial
  begin
    ce = 1'h1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {line_start, frame_start, disp_active, chroma_line_done} = '0;
    {slow, presetn, er} = '0;
    rd = 32'h0;
    n_fail = 0;
    comparisons = 0;
    key = 8'h3C;
    amatch = 8'hE1;
    amiss = 8'h1E;
    cu = 8'h94;
    cv = 8'h6B;
    msk = '{16'h0, 16'h0, 16'h0};
    cfg = CTRL_RST;
    void'($urandom(74));
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, OFS_CTRL, 32'h0);
    chk("ctrl_rst", rd, {19'h0, CTRL_RST});
    apb(1'h0, OFS_KEY, 32'h0);
    chk("key_rst", rd, KEY_RST);
    apb(1'h0, OFS_MASK_Y, 32'h0);
    chk("mask_rst", rd, {16'h0, MASK_RST});
    apb(1'h0, 8'h24, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    wr(OFS_KEY, {8'h0, amiss, amatch, key});
    apb(1'h0, OFS_KEY, 32'h0);
    chk("key_rd", rd, {8'h0, amiss, amatch, key});
    for (int i = 0; i < 256; i++)
      wr(OFS_TABLE, {i[7:0], tval(2, i[7:0]), tval(1, i[7:0]),
         tval(0, i[7:0])});
    run(FMT_8, PT_GFX, 3'h1, 1'h1, 6);
    run(FMT_P16, PT_GFX, 3'h1, 1'h1, 6);
    slow <= 1'h1;
    run(FMT_16, PT_GFX, 3'h1, 1'h1, 6);
    run(FMT_32, PT_GFX, 3'h1, 1'h1, 6);
    slow <= 1'h0;
    msk = '{16'hA0F0, 16'h050F, 16'h0000};
    for (int c = 0; c < 3; c++)
      wr(OFS_MASK_Y + 8'(4 * c), {16'h0, msk[c]});
    run(FMT_8, PT_GFX, 3'h0, 1'h1, 8);
    run(FMT_16, PT_GFX, 3'h0, 1'h1, 8);
    run(FMT_32, PT_GFX, 3'h0, 1'h1, 8);
    run(FMT_8, PT_GFX, 3'h4, 1'h1, 8);
    load_chroma();
    run(FMT_8, PT_VID, 3'h3, 1'h1, 8);
    run(FMT_8, PT_VID, 3'h3, 1'h0, 8);
    run(FMT_8, PT_MIX, 3'h3, 1'h1, 8);
    run(FMT_8, PT_MIX, 3'h4, 1'h1, 8);
    tally_and_finish();
  end
endmodule
